// ### common/ppd_defines.svh
// constants for the pulse position deviation loop: offsets, fields, resets, timing
// assumes a 200 MHz reference clock and a 32-bit AXI4-Lite register bus
`ifndef PPD_DEFINES_SVH
`define PPD_DEFINES_SVH

// register byte offsets
`define PPD_OFS_CTRL      8'h00
`define PPD_OFS_INPOS_W   8'h04
`define PPD_OFS_EXCESS    8'h08
`define PPD_OFS_MON_SEL   8'h0c
`define PPD_OFS_POS_GAIN  8'h10
`define PPD_OFS_FF_GAIN   8'h14
`define PPD_OFS_FF_FILT   8'h18
`define PPD_OFS_MONITOR   8'h1c
`define PPD_OFS_STATUS    8'h20
`define PPD_OFS_IRQ_STAT  8'h24
`define PPD_OFS_IRQ_MASK  8'h28
`define PPD_OFS_DROOP     8'h2c

// control register fields
`define PPD_CTRL_SRC_LSB  0
`define PPD_CTRL_CLR_BIT  2

// reset values
`define PPD_RST_SRC       2'h0
`define PPD_RST_CLR_SEL   1'h1
`define PPD_RST_INPOS_W   15'h0064
`define PPD_RST_EXCESS    16'h0028
`define PPD_RST_MON_SEL   16'h270f
`define PPD_RST_POS_GAIN  8'h19
`define PPD_RST_FF_GAIN   7'h00
`define PPD_RST_FF_FILT   13'h0000

// special values and scales
`define PPD_EXCESS_OFF    16'h270f
`define PPD_MON_FREQ      16'h270f
`define PPD_EXCESS_SCALE  32'h000003e8
`define PPD_DIGITS_DIV    32'h00002710
`define PPD_PCT_DIV       48'h000000000064

// interrupt status and mask bits
`define PPD_EV_FAULT      0
`define PPD_EV_INPOS      1
`define PPD_EV_DEVCLR     2

// timing: rate window for the feed-forward path, 1 ms
`define PPD_CLK_PERIOD_PS 5000
`define PPD_TICK_TIME_PS  1000000000
`define PPD_TICK_CYCLES   ((`PPD_TICK_TIME_PS + `PPD_CLK_PERIOD_PS - 1) / `PPD_CLK_PERIOD_PS)

`endif

// ### common/ppd_pkg.sv
// types shared by the pulse position deviation loop files
// assumes ppd_defines.svh supplies every number
package ppd_pkg;
	typedef enum logic [1:0] {
		PPD_SRC_FEED   = 2'b00,
		PPD_SRC_OPTION = 2'b01,
		PPD_SRC_BASE   = 2'b10
	} ppd_src_t;

	typedef enum logic [1:0] {
		PPD_AXI_IDLE = 2'b00,
		PPD_AXI_RESP = 2'b01
	} ppd_axi_state_t;
endpackage : ppd_pkg

// ### src/ppd_lag_filter.sv
// first-order lag on the feed-forward command, stepped once per tick
// assumes tick is a one-cycle enable and the time constant is in ticks
`timescale 1ns/10ps
`include "ppd_defines.svh"

module ppd_lag_filter
	import ppd_pkg::*;
(
	input  wire logic               i_ref_clk,
	input  wire logic               i_sys_rst,
	input  wire logic               i_tick,
	input  wire logic signed [31:0] i_cmd,
	input  wire logic        [12:0] i_tc_ticks,
	output logic signed      [31:0] o_filt
);
	logic signed [31:0] y_reg;
	logic signed [31:0] y_next;
	logic signed [32:0] diff;
	logic signed [32:0] step;

	// y += (x - y) / (tc + 1); a zero constant passes straight through
	always_comb begin
		diff   = 33'(i_cmd) - 33'(y_reg);
		step   = diff / $signed({20'h00000, i_tc_ticks} + 33'sh1);
		y_next = y_reg;
		if (i_tick) begin
			y_next = 32'(33'(y_reg) + step);
		end
	end

	// registered state only
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			y_reg <= 32'sh0;
		end else begin
			y_reg <= y_next;
		end
	end

	assign o_filt = y_reg;

	// a zero constant must reach the command in one tick
	lag_pass_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_tick && i_tc_ticks == 13'h0) |=> (y_reg == $past(i_cmd)))
		else $error("lag filter with zero constant did not pass input");
endmodule : ppd_lag_filter

// ### src/ppd_core.sv
// position deviation loop: droop counter, in-position, excess fault, monitors, gains
// assumes asynchronous pins (pulses, servo on, base off, clears) and an AXI4-Lite master
//
// Functional notes
// - source selector: 0 contact feeds, 1 option pulse train, 2 base pulse train
// - in-position when droop magnitude is below the configured width
// - in-position shown on its own dedicated output
// - excess fault when droop magnitude exceeds the configured level
// - level 9999 disables new excess detection; a latched fault holds until base shutoff
// - monitor selects lower/upper command, feedback, droop digits, or frequency
// - pulse counting starts only with servo on
// - cumulative counters clear on base shutoff or cumulative clear
// - clear select 0: droop clears on deviation clear rising edge
// - proportional gain 0..150 per second, default 25, on droop
// - feed-forward 0..100 percent compensates droop tracking lag
// - feed-forward goes through first-order lag, 0..5 s constant
// - feed-forward does not change stiffness at standstill
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`include "ppd_defines.svh"

module ppd_core
	import ppd_pkg::*;
#(
	parameter int TICK_CYCLES = `PPD_TICK_CYCLES
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_feed_pulse,
	input  wire logic        i_feed_dir,
	input  wire logic        i_opt_pulse,
	input  wire logic        i_opt_dir,
	input  wire logic        i_base_pulse,
	input  wire logic        i_base_dir,
	input  wire logic        i_enc_pulse,
	input  wire logic        i_enc_dir,
	input  wire logic        i_servo_on,
	input  wire logic        i_base_off,
	input  wire logic        i_cumulative_clear_in,
	input  wire logic        i_deviation_clear_in,
	input  wire logic [15:0] i_out_freq,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic             o_in_position_out,
	output logic             o_position_error_fault,
	output logic signed [31:0] o_speed_cmd,
	output logic             o_irq
);
	// ---- pin synchronisers: two flops, then a third stage for edges
	logic [11:0] pin_raw, pin_s1, pin_s2, pin_s3;
	assign pin_raw = {i_deviation_clear_in, i_cumulative_clear_in, i_base_off, i_servo_on,
	                  i_enc_dir, i_enc_pulse, i_base_dir, i_base_pulse,
	                  i_opt_dir, i_opt_pulse, i_feed_dir, i_feed_pulse};
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			pin_s1 <= 12'h000;
			pin_s2 <= 12'h000;
			pin_s3 <= 12'h000;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end
	logic [11:0] rise;
	assign rise = pin_s2 & ~pin_s3;
	logic servo_on, base_off, cum_clr, dev_clr_rise, dev_clr_lvl;
	assign servo_on     = pin_s2[8];
	assign base_off     = pin_s2[9];
	assign cum_clr      = pin_s2[10];
	assign dev_clr_lvl  = pin_s2[11];
	assign dev_clr_rise = rise[11];

	// ---- configuration registers
	logic [1:0]  src_reg, src_next;
	logic        clr_sel_reg, clr_sel_next;
	logic [14:0] inpos_w_reg, inpos_w_next;
	logic [15:0] excess_reg, excess_next;
	logic [15:0] mon_sel_reg, mon_sel_next;
	logic [7:0]  kp_reg, kp_next;
	logic [6:0]  ffg_reg, ffg_next;
	logic [12:0] fft_reg, fft_next;
	logic [2:0]  ist_reg, ist_next, imask_reg, imask_next;

	// ---- command selection and counting
	logic cmd_pulse, cmd_dir, fb_pulse, fb_dir;
	always_comb begin
		case (ppd_src_t'(src_reg))
			PPD_SRC_FEED: begin
				cmd_pulse = rise[0];
				cmd_dir   = pin_s2[1];
			end
			PPD_SRC_OPTION: begin
				cmd_pulse = rise[2];
				cmd_dir   = pin_s2[3];
			end
			PPD_SRC_BASE: begin
				cmd_pulse = rise[4];
				cmd_dir   = pin_s2[5];
			end
			default: begin
				cmd_pulse = 1'b0;
				cmd_dir   = 1'b0;
			end
		endcase
		fb_pulse = rise[6];
		fb_dir   = pin_s2[7];
	end

	logic signed [31:0] cmd_cum_reg, cmd_cum_next, fb_cum_reg, fb_cum_next, droop_reg, droop_next;
	logic signed [31:0] cmd_step, fb_step;
	// dir high counts down; counting only under servo on
	always_comb begin
		cmd_step     = (servo_on && cmd_pulse) ? (cmd_dir ? -32'sh1 : 32'sh1) : 32'sh0;
		fb_step      = (servo_on && fb_pulse) ? (fb_dir ? -32'sh1 : 32'sh1) : 32'sh0;
		cmd_cum_next = cmd_cum_reg + cmd_step;
		fb_cum_next  = fb_cum_reg + fb_step;
		if (base_off || cum_clr) begin
			cmd_cum_next = 32'sh0;
			fb_cum_next  = 32'sh0;
		end
		droop_next = droop_reg + cmd_step - fb_step;
		// droop cannot be held without servo; clear select 1 clears on level
		if (!servo_on || (clr_sel_reg == 1'b0 && dev_clr_rise) || (clr_sel_reg && dev_clr_lvl)) begin
			droop_next = 32'sh0;
		end
	end

	// ---- droop checks
	logic [31:0] droop_abs;
	logic        inpos_now, excess_now;
	always_comb begin
		droop_abs  = droop_reg[31] ? 32'(-droop_reg) : 32'(droop_reg);
		inpos_now  = droop_abs < {17'h00000, inpos_w_reg};
		excess_now = (excess_reg != `PPD_EXCESS_OFF) &&
		             (droop_abs > 32'({16'h0000, excess_reg} * `PPD_EXCESS_SCALE));
	end

	// ---- feed-forward: command rate per tick, scaled, then lag filtered
	logic [31:0]        tick_cnt_reg, tick_cnt_next;
	logic               tick;
	logic signed [31:0] rate_acc_reg, rate_acc_next, rate_reg, rate_next;
	logic signed [31:0] ff_raw, ff_filt;
	logic signed [47:0] ff_prod;
	always_comb begin
		tick          = tick_cnt_reg == 32'(TICK_CYCLES - 1);
		tick_cnt_next = tick ? 32'h0 : tick_cnt_reg + 32'h1;
		rate_acc_next = tick ? cmd_step : rate_acc_reg + cmd_step;
		rate_next     = tick ? rate_acc_reg : rate_reg;
		// zero at standstill, so stiffness comes from the gain term alone
		ff_prod       = 48'(rate_reg) * $signed({41'h0, ffg_reg});
		ff_raw        = 32'(ff_prod / $signed(`PPD_PCT_DIV));
	end

	ppd_lag_filter u_lag (
		.i_ref_clk (i_ref_clk),
		.i_sys_rst (i_sys_rst),
		.i_tick    (tick),
		.i_cmd     (ff_raw),
		.i_tc_ticks(fft_reg),
		.o_filt    (ff_filt)
	);

	// ---- speed command and loop outputs
	logic signed [31:0] speed_next;
	logic               fault_next;
	logic signed [39:0] kp_prod;
	always_comb begin
		kp_prod    = 40'(droop_reg) * $signed({32'h0, kp_reg});
		speed_next = 32'(kp_prod) + ff_filt;
		// fault latches until the base is shut off
		fault_next = base_off ? 1'b0 : (o_position_error_fault | excess_now);
	end

	// ---- interrupt status: set wins over write-one-clear
	logic [2:0] ev;
	logic       ist_wr;
	logic [31:0] wdata_q;
	assign ev = {servo_on && dev_clr_rise && !clr_sel_reg, inpos_now && !o_in_position_out,
	             excess_now && !o_position_error_fault};

	// ---- AXI4-Lite slave
	ppd_axi_state_t wst_reg, wst_next;
	logic        aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [7:0]  awaddr_reg, awaddr_next, raddr;
	logic [31:0] wdata_reg, wdata_next, rdata_next;
	logic [1:0]  bresp_next, rresp_next;
	logic        bvalid_next, rvalid_next, do_wr, do_rd, wr_hit, rd_hit;
	logic [31:0] mon_val, mon_abs;
	logic signed [31:0] mon_src;

	// monitor: lower/upper four decimal digits of the selected count
	always_comb begin
		case (mon_sel_reg)
			16'h0000, 16'h0001: mon_src = cmd_cum_reg;
			16'h0002, 16'h0003: mon_src = fb_cum_reg;
			default:            mon_src = droop_reg;
		endcase
		mon_abs = mon_src[31] ? 32'(-mon_src) : 32'(mon_src);
		if (mon_sel_reg == `PPD_MON_FREQ) begin
			mon_val = {16'h0000, i_out_freq};
		end else if (mon_sel_reg > 16'h0005) begin
			mon_val = 32'h0;
		end else if (mon_sel_reg[0]) begin
			mon_val = (mon_abs / `PPD_DIGITS_DIV) % `PPD_DIGITS_DIV;
		end else begin
			mon_val = mon_abs % `PPD_DIGITS_DIV;
		end
	end

	always_comb begin
		aw_have_next = aw_have_reg | (i_awvalid & o_awready);
		w_have_next  = w_have_reg | (i_wvalid & o_wready);
		awaddr_next  = (i_awvalid & o_awready) ? i_awaddr : awaddr_reg;
		wdata_next   = (i_wvalid & o_wready) ? i_wdata : wdata_reg;
		do_wr        = aw_have_reg && w_have_reg && wst_reg == PPD_AXI_IDLE;
		wst_next     = wst_reg;
		bvalid_next  = o_bvalid;
		bresp_next   = o_bresp;
		wr_hit       = awaddr_reg[1:0] == 2'b00 && awaddr_reg <= `PPD_OFS_IRQ_MASK &&
		               awaddr_reg != `PPD_OFS_MONITOR && awaddr_reg != `PPD_OFS_STATUS;
		case (wst_reg)
			PPD_AXI_IDLE: begin
				if (do_wr) begin
					wst_next     = PPD_AXI_RESP;
					bvalid_next  = 1'b1;
					bresp_next   = wr_hit ? 2'b00 : 2'b10;
					aw_have_next = 1'b0;
					w_have_next  = 1'b0;
				end
			end
			PPD_AXI_RESP: begin
				if (i_bready) begin
					wst_next    = PPD_AXI_IDLE;
					bvalid_next = 1'b0;
				end
			end
			default: wst_next = PPD_AXI_IDLE;
		endcase
		do_rd       = i_arvalid && o_arready;
		raddr       = i_araddr;
		rvalid_next = do_rd ? 1'b1 : (o_rvalid && !i_rready);
		rd_hit      = raddr[1:0] == 2'b00 && raddr <= `PPD_OFS_DROOP;
		rresp_next  = do_rd ? (rd_hit ? 2'b00 : 2'b10) : o_rresp;
		rdata_next  = o_rdata;
		if (do_rd) begin
			case (raddr)
				`PPD_OFS_CTRL:     rdata_next = {29'h0, clr_sel_reg, src_reg};
				`PPD_OFS_INPOS_W:  rdata_next = {17'h0, inpos_w_reg};
				`PPD_OFS_EXCESS:   rdata_next = {16'h0, excess_reg};
				`PPD_OFS_MON_SEL:  rdata_next = {16'h0, mon_sel_reg};
				`PPD_OFS_POS_GAIN: rdata_next = {24'h0, kp_reg};
				`PPD_OFS_FF_GAIN:  rdata_next = {25'h0, ffg_reg};
				`PPD_OFS_FF_FILT:  rdata_next = {19'h0, fft_reg};
				`PPD_OFS_MONITOR:  rdata_next = mon_val;
				`PPD_OFS_STATUS:   rdata_next = {29'h0, servo_on, o_position_error_fault, o_in_position_out};
				`PPD_OFS_IRQ_STAT: rdata_next = {29'h0, ist_reg};
				`PPD_OFS_IRQ_MASK: rdata_next = {29'h0, imask_reg};
				`PPD_OFS_DROOP:    rdata_next = droop_reg;
				default:           rdata_next = 32'h0;
			endcase
		end
	end

	// register writes; the byte strobes are ignored, so every accepted write alters the whole register
	always_comb begin
		wdata_q      = wdata_reg;
		ist_wr       = do_wr && awaddr_reg == `PPD_OFS_IRQ_STAT;
		src_next     = src_reg;
		clr_sel_next = clr_sel_reg;
		inpos_w_next = inpos_w_reg;
		excess_next  = excess_reg;
		mon_sel_next = mon_sel_reg;
		kp_next      = kp_reg;
		ffg_next     = ffg_reg;
		fft_next     = fft_reg;
		imask_next   = imask_reg;
		if (do_wr) begin
			case (awaddr_reg)
				`PPD_OFS_CTRL: begin
					src_next     = wdata_q[`PPD_CTRL_SRC_LSB +: 2];
					clr_sel_next = wdata_q[`PPD_CTRL_CLR_BIT];
				end
				`PPD_OFS_INPOS_W:  inpos_w_next = wdata_q[14:0];
				`PPD_OFS_EXCESS:   excess_next  = wdata_q[15:0];
				`PPD_OFS_MON_SEL:  mon_sel_next = wdata_q[15:0];
				`PPD_OFS_POS_GAIN: kp_next      = wdata_q[7:0];
				`PPD_OFS_FF_GAIN:  ffg_next     = wdata_q[6:0];
				`PPD_OFS_FF_FILT:  fft_next     = wdata_q[12:0];
				`PPD_OFS_IRQ_MASK: imask_next   = wdata_q[2:0];
				default:           src_next     = src_reg;
			endcase
		end
		ist_next = (ist_reg & ~(ist_wr ? wdata_q[2:0] : 3'h0)) | ev;
	end

	// all state registered here except the pin synchronisers and the lag filter
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			src_reg <= `PPD_RST_SRC;
			clr_sel_reg <= `PPD_RST_CLR_SEL;
			inpos_w_reg <= `PPD_RST_INPOS_W;
			excess_reg <= `PPD_RST_EXCESS;
			mon_sel_reg <= `PPD_RST_MON_SEL;
			kp_reg <= `PPD_RST_POS_GAIN;
			ffg_reg <= `PPD_RST_FF_GAIN;
			fft_reg <= `PPD_RST_FF_FILT;
			ist_reg <= 3'h0;
			imask_reg <= 3'h0;
			cmd_cum_reg <= 32'sh0;
			fb_cum_reg <= 32'sh0;
			droop_reg <= 32'sh0;
			tick_cnt_reg <= 32'h0;
			rate_acc_reg <= 32'sh0;
			rate_reg <= 32'sh0;
			wst_reg <= PPD_AXI_IDLE;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= 2'b00;
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rresp <= 2'b00;
			o_rdata <= 32'h0;
			o_in_position_out <= 1'b0;
			o_position_error_fault <= 1'b0;
			o_speed_cmd <= 32'sh0;
			o_irq <= 1'b0;
		end else begin
			src_reg <= src_next;
			clr_sel_reg <= clr_sel_next;
			inpos_w_reg <= inpos_w_next;
			excess_reg <= excess_next;
			mon_sel_reg <= mon_sel_next;
			kp_reg <= kp_next;
			ffg_reg <= ffg_next;
			fft_reg <= fft_next;
			ist_reg <= ist_next;
			imask_reg <= imask_next;
			cmd_cum_reg <= cmd_cum_next;
			fb_cum_reg <= fb_cum_next;
			droop_reg <= droop_next;
			tick_cnt_reg <= tick_cnt_next;
			rate_acc_reg <= rate_acc_next;
			rate_reg <= rate_next;
			wst_reg <= wst_next;
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			o_awready <= !aw_have_next;
			o_wready <= !w_have_next;
			o_bvalid <= bvalid_next;
			o_bresp <= bresp_next;
			o_arready <= !rvalid_next;
			o_rvalid <= rvalid_next;
			o_rresp <= rresp_next;
			o_rdata <= rdata_next;
			o_in_position_out <= inpos_now;
			o_position_error_fault <= fault_next;
			o_speed_cmd <= speed_next;
			o_irq <= |(ist_next & imask_next);
		end
	end

	inpos_track_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		1 |=> (o_in_position_out == $past(inpos_now)))
		else $error("in-position output does not follow droop width");
	fault_sets_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(excess_now && !base_off) |=> o_position_error_fault)
		else $error("excess droop did not raise fault");
	fault_disabled_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(excess_reg == `PPD_EXCESS_OFF && !o_position_error_fault) |=> !o_position_error_fault)
		else $error("fault raised while disabled");
	servo_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(!servo_on && !base_off && !cum_clr) |=> ($stable(cmd_cum_reg) && droop_reg == 32'sh0))
		else $error("pulses counted without servo on");
	cum_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(base_off || cum_clr) |=> (cmd_cum_reg == 32'sh0 && fb_cum_reg == 32'sh0))
		else $error("cumulative counters not cleared");
	dev_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(!clr_sel_reg && dev_clr_rise) |=> (droop_reg == 32'sh0))
		else $error("droop not cleared on clear edge");
	droop_sum_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(servo_on && !dev_clr_rise && !dev_clr_lvl && fb_pulse && !fb_dir && !cmd_pulse)
		|=> (droop_reg == $past(droop_reg) - 32'sh1))
		else $error("feedback pulse did not decrement droop");
	source_opt_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(src_reg == 2'h1 && servo_on && !base_off && !cum_clr && rise[2] && !pin_s2[3])
		|=> (cmd_cum_reg == $past(cmd_cum_reg) + 32'sh1))
		else $error("option pulse not counted when selected");
	standstill_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(droop_reg == 32'sh0 && ff_filt == 32'sh0) |=> (o_speed_cmd == 32'sh0))
		else $error("speed command nonzero at standstill");
	irq_level_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(ist_reg & imask_reg) != 3'h0 |-> o_irq)
		else $error("interrupt low with unmasked status set");
endmodule : ppd_core

// ### verification/ppd_pulse_model.sv
// partner model: pulse train source, used for the command unit and the encoder
// assumes the bench raises i_go for one cycle and waits for o_busy to fall
`timescale 1ns/10ps

module ppd_pulse_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_go,
	input  wire logic [15:0] i_count,
	input  wire logic        i_dir,
	input  wire logic [3:0]  i_half,
	output logic             o_pulse,
	output logic             o_dir,
	output logic             o_busy
);
	// direction settles a half period before the first edge; half period of
	// three clocks or more, so the synchronised pin never misses a pulse
	initial begin
		o_pulse = 1'b0;
		o_dir   = 1'b0;
		o_busy  = 1'b0;
		forever begin
			@(posedge i_ref_clk);
			if (i_go) begin
				o_busy <= 1'b1;
				o_dir  <= i_dir;
				for (int k = 0; k < i_count; k++) begin
					repeat (i_half) @(posedge i_ref_clk);
					o_pulse <= 1'b1;
					repeat (i_half) @(posedge i_ref_clk);
					o_pulse <= 1'b0;
				end
				repeat (i_half) @(posedge i_ref_clk);
				o_busy <= 1'b0;
			end
		end
	end
endmodule : ppd_pulse_model

// ### verification/ppd_core_bench.sv
// self-checking bench for ppd_core: registers, droop, in-position, fault, clears
// assumes two pulse models drive the option and base command pins and the encoder pins
`timescale 1ns/10ps
`include "ppd_defines.svh"

module ppd_core_bench;
	logic               clk, rst, servo, base_off, cum_clr, dev_clr;
	logic [15:0]        freq, c_cnt, e_cnt;
	logic [7:0]         awaddr, araddr;
	logic [31:0]        wdata, rdata, rd;
	logic               awvalid, wvalid, bready, arvalid, rready;
	logic               awready, wready, bvalid, arready, rvalid, inpos, fault, irq;
	logic [1:0]         bresp, rresp, rs;
	logic signed [31:0] speed;
	logic               c_go, e_go, c_dir, e_dir, c_pul, e_pul, c_pdir, e_pdir, c_busy, e_busy;
	int                 errors, cmp_count, cycles;

	// 200 MHz reference clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// prompt command unit, slow encoder
	ppd_pulse_model CMD (.i_ref_clk(clk), .i_go(c_go), .i_count(c_cnt), .i_dir(c_dir), .i_half(4'h3),
		.o_pulse(c_pul), .o_dir(c_pdir), .o_busy(c_busy));
	ppd_pulse_model ENC (.i_ref_clk(clk), .i_go(e_go), .i_count(e_cnt), .i_dir(e_dir), .i_half(4'h6),
		.o_pulse(e_pul), .o_dir(e_pdir), .o_busy(e_busy));

	// short rate window keeps the feed-forward settling quick
	ppd_core #(.TICK_CYCLES(20)) DUT (.i_ref_clk(clk), .i_sys_rst(rst),
		.i_feed_pulse(1'b0), .i_feed_dir(1'b0), .i_opt_pulse(c_pul), .i_opt_dir(c_pdir),
		.i_base_pulse(c_pul), .i_base_dir(c_pdir), .i_enc_pulse(e_pul), .i_enc_dir(e_pdir),
		.i_servo_on(servo), .i_base_off(base_off), .i_cumulative_clear_in(cum_clr),
		.i_deviation_clear_in(dev_clr), .i_out_freq(freq), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.o_in_position_out(inpos), .o_position_error_fault(fault), .o_speed_cmd(speed), .o_irq(irq));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// write cycle; both channels offered together, response code left in rs
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit got = 0;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!got) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				got = 1;
				rs = bresp;
				bready <= 1'b0;
			end
		end
	endtask : wr

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
		bit got = 0;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!got) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				got = 1;
				rd = rdata;
				rs = rresp;
				rready <= 1'b0;
			end
		end
		chk(rd, exp);
	endtask : chk_reg

	task automatic mon(input logic [15:0] sel, input logic [31:0] exp);
		wr(`PPD_OFS_MON_SEL, {16'h0, sel});
		chk_reg(`PPD_OFS_MONITOR, exp);
	endtask : mon

	// one burst from the command unit or the encoder, then let the pins settle
	task automatic pulses(input bit enc, input logic [15:0] n, input logic dir);
		@(posedge clk);
		c_cnt <= n;
		e_cnt <= n;
		c_dir <= dir;
		e_dir <= dir;
		c_go  <= !enc;
		e_go  <= enc;
		@(posedge clk);
		c_go <= 1'b0;
		e_go <= 1'b0;
		@(posedge clk);
		while (c_busy || e_busy) @(posedge clk);
		repeat (8) @(posedge clk);
	endtask : pulses

	task automatic t_regs();
		chk_reg(`PPD_OFS_CTRL, 32'h4);
		chk_reg(`PPD_OFS_INPOS_W, 32'd100);
		chk_reg(`PPD_OFS_EXCESS, 32'd40);
		chk_reg(`PPD_OFS_MON_SEL, 32'd9999);
		chk_reg(`PPD_OFS_POS_GAIN, 32'd25);
		chk_reg(`PPD_OFS_FF_FILT, 32'h0);
		chk_reg(8'h30, 32'h0);
		chk({30'h0, rs}, 32'h2);
		wr(`PPD_OFS_DROOP, 32'h5);
		chk({30'h0, rs}, 32'h2);
		wr(`PPD_OFS_INPOS_W, 32'h3);
		wr(`PPD_OFS_CTRL, 32'h1);
	endtask : t_regs

	task automatic t_count();
		servo <= 1'b1;
		pulses(0, 16'd10, 1'b0);
		pulses(1, 16'd4, 1'b0);
		chk_reg(`PPD_OFS_DROOP, 32'h6);
		chk({31'h0, inpos}, 32'h0);
		wr(`PPD_OFS_FF_GAIN, 32'd100);
		repeat (60) @(posedge clk);
		chk(speed, 32'd150);
		// manual gain change, kept inside the usual range with no tuning running
		wr(`PPD_OFS_POS_GAIN, 32'd20);
		repeat (2) @(posedge clk);
		chk(speed, 32'd120);
		mon(16'd0, 32'd10);
		mon(16'd2, 32'd4);
		mon(16'd4, 32'd6);
		mon(16'd9999, {16'h0, freq});
		pulses(1, 16'd8, 1'b0);
		chk_reg(`PPD_OFS_DROOP, 32'hfffffffe);
		chk({31'h0, inpos}, 32'h1);
		mon(16'd5, 32'd0);
		wr(`PPD_OFS_CTRL, 32'h0);
		pulses(0, 16'd5, 1'b0);
		chk_reg(`PPD_OFS_DROOP, 32'hfffffffe);
		// base pulse train shares the command model; only source 2 counts it
		wr(`PPD_OFS_CTRL, 32'h2);
		pulses(0, 16'd1, 1'b0);
		chk_reg(`PPD_OFS_DROOP, 32'hffffffff);
		wr(`PPD_OFS_CTRL, 32'h1);
	endtask : t_count

	task automatic t_fault();
		wr(`PPD_OFS_IRQ_MASK, 32'h1);
		wr(`PPD_OFS_EXCESS, 32'h0);
		repeat (4) @(posedge clk);
		chk({31'h0, fault}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(`PPD_OFS_EXCESS, 32'd9999);
		base_off <= 1'b1;
		repeat (6) @(posedge clk);
		base_off <= 1'b0;
		repeat (6) @(posedge clk);
		chk({31'h0, fault}, 32'h0);
		mon(16'd0, 32'd0);
		wr(`PPD_OFS_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		pulses(0, 16'd50, 1'b0);
		chk({31'h0, fault}, 32'h0);
	endtask : t_fault

	task automatic t_clear();
		dev_clr <= 1'b1;
		repeat (8) @(posedge clk);
		chk_reg(`PPD_OFS_DROOP, 32'h0);
		dev_clr <= 1'b0;
		pulses(0, 16'd3, 1'b0);
		chk_reg(`PPD_OFS_DROOP, 32'h3);
		cum_clr <= 1'b1;
		repeat (6) @(posedge clk);
		mon(16'd2, 32'd0);
		cum_clr <= 1'b0;
	endtask : t_clear

	// counts taken while servo is off must not show up after it returns
	task automatic t_servo();
		servo <= 1'b0;
		pulses(0, 16'd5, 1'b0);
		servo <= 1'b1;
		repeat (6) @(posedge clk);
		chk_reg(`PPD_OFS_DROOP, 32'h0);
		mon(16'd0, 32'd0);
	endtask : t_servo

	task automatic finish_test();
		if (errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	// hang guard, far above the thousand or so cycles the run needs
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			errors++;
			finish_test();
		end
	end

	initial begin
		{rst, servo, base_off, cum_clr, dev_clr} = 5'h10;
		{awvalid, wvalid, bready, arvalid, rready, c_go, e_go, c_dir, e_dir} = 9'h0;
		{awaddr, araddr, wdata, c_cnt, e_cnt} = 80'h0;
		{errors, cmp_count, cycles} = 96'h0;
		freq = 16'h1234;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_regs();
		t_count();
		t_fault();
		t_clear();
		t_servo();
		finish_test();
	end
endmodule : ppd_core_bench
